/* logic/ctec_map.svh */
// Register map, field positions and reset values of the charge time edge control block
`ifndef CTEC_MAP_SVH
`define CTEC_MAP_SVH

`define CTEC_ADDR_W        8
`define CTEC_ADDR_CTRL     8'h00
`define CTEC_ADDR_CLR      8'h04
`define CTEC_ADDR_SET      8'h08
`define CTEC_ADDR_INV      8'h0C
`define CTEC_CTRL_RESET    32'h0000_0000
`define CTEC_IMPL_MASK     32'hFFFC_BFFF
`define CTEC_BIT_E2_FLAG   25
`define CTEC_BIT_E1_FLAG   24
`define CTEC_RESP_OKAY     2'h0
`define CTEC_RESP_SLVERR   2'h2
`define CTEC_SRC_W         22
`define CTEC_SYNC_STAGES   3

`endif

/* logic/ctec_pkg.sv */
// Types of the charge time edge control block
package ctec_pkg;

	typedef struct packed {
		logic       first_edge_sense_mode;
		logic       first_edge_polarity;
		logic [3:0] first_edge_source_sel;
		logic       second_edge_flag;
		logic       first_edge_flag;
		logic       second_edge_sense_mode;
		logic       second_edge_polarity;
		logic [3:0] second_edge_source_sel;
		logic [1:0] unused_hi;
		logic       unit_on;
		logic       unused_mid;
		logic       idle_stop;
		logic       delay_gen_enable;
		logic       edge_gate_enable;
		logic       edge_order_enable;
		logic       source_ground_enable;
		logic       trigger_out_enable;
		logic [5:0] current_trim;
		logic [1:0] current_range;
	} ctec_ctrl_s;

	// Raw event sources, 22 bits in all
	typedef struct packed {
		logic       peripheral_bus_clock;
		logic [2:0] comparator_out;
		logic [2:0] capture_event;
		logic       compare_unit_one;
		logic       timer_one_event;
		logic [12:0] edge_pin;
	} ctec_src_s;

	typedef struct packed {
		logic       source_on;
		logic       source_ground;
		logic [5:0] current_trim;
		logic [1:0] current_range;
	} ctec_analog_s;

endpackage : ctec_pkg

/* logic/ctec_top.sv */
// Edge control logic of the charge time measurement unit with its AXI4-Lite register slave
//
// Design decisions made here: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ns
`include "ctec_map.svh"

module ctec_top
	import ctec_pkg::*;
(
	input  wire logic                     aclk,          // Bus clock, 10 MHz
	input  wire logic                     aresetn,       // Synchronous reset, active low
	input  wire logic [`CTEC_ADDR_W-1:0]  awaddr,        // Write address
	input  wire logic [2:0]               awprot,        // Unused protection
	input  wire logic                     awvalid,       // Write address valid
	output      logic                     awready,       // Write address ready
	input  wire logic [31:0]              wdata,         // Write data
	input  wire logic [3:0]               wstrb,         // Byte enables
	input  wire logic                     wvalid,        // Write data valid
	output      logic                     wready,        // Write data ready
	output      logic [1:0]               bresp,         // Write response
	output      logic                     bvalid,        // Write response valid
	input  wire logic                     bready,        // Write response ready
	input  wire logic [`CTEC_ADDR_W-1:0]  araddr,        // Read address
	input  wire logic [2:0]               arprot,        // Unused protection
	input  wire logic                     arvalid,       // Read address valid
	output      logic                     arready,       // Read address ready
	output      logic [31:0]              rdata,         // Read data
	output      logic [1:0]               rresp,         // Read response
	output      logic                     rvalid,        // Read data valid
	input  wire logic                     rready,        // Read data ready
	input  wire ctec_src_s                sources,       // Asynchronous edge sources
	input  wire logic                     idle_mode,     // Chip is in idle mode
	output      logic                     unit_active,   // Unit enabled and not idle-stopped
	output      logic                     first_edge_flag,  // First edge has occurred
	output      logic                     second_edge_flag, // Second edge has occurred
	output      logic                     trigger_out,   // One-cycle trigger on second edge
	output      logic                     delay_pulse,   // Delay pulse between edges
	output      ctec_analog_s             analog_ctrl    // Current source control
);

	// Bus write state
	logic                     aw_held;
	logic                     w_held;
	logic [`CTEC_ADDR_W-1:0]  aw_addr_q;
	logic [31:0]              w_data_q;
	logic [3:0]               w_strb_q;
	logic                     do_write;
	logic                     write_hit;
	logic                     read_hit;

	// Control register and its decoded view
	logic [31:0]              ctrl;
	logic [31:0]              next_ctrl;
	ctec_ctrl_s               cf;

	// Source conditioning
	logic [`CTEC_SRC_W-1:0]   sync1;
	logic [`CTEC_SRC_W-1:0]   sync2;
	logic [`CTEC_SRC_W-1:0]   sync3;
	logic [`CTEC_SRC_W-1:0]   src_stable;
	ctec_src_s                ss;
	logic [15:0]              first_choices;
	logic [15:0]              second_choices;
	logic                     first_in;
	logic                     second_in;
	logic                     first_prev;
	logic                     second_prev;
	logic                     running;
	logic                     first_set;
	logic                     second_set;

	assign cf = ctec_ctrl_s'(ctrl);

	// Byte lane mask from the strobes
	function automatic logic [31:0] lane_mask(input logic [3:0] strb);
		logic [31:0] m;
		m = 32'h0000_0000;
		for (int i = 0; i < 4; i++)
		begin
			m[i*8 +: 8] = {8{strb[i]}};
		end
		return m;
	endfunction : lane_mask

	// Address decode, shared by the read and write paths
	function automatic logic addr_mapped(input logic [`CTEC_ADDR_W-1:0] a);
		return (a == `CTEC_ADDR_CTRL) || (a == `CTEC_ADDR_CLR) ||
			(a == `CTEC_ADDR_SET) || (a == `CTEC_ADDR_INV);
	endfunction : addr_mapped

	// Qualified event of one edge channel
	function automatic logic edge_event(
		input logic edge_mode,
		input logic polarity,
		input logic cur,
		input logic prev
	);
		logic act;
		logic act_prev;
		act      = (cur == polarity);
		act_prev = (prev == polarity);
		return edge_mode ? (act && !act_prev) : act;
	endfunction : edge_event

	// Write channel: address and data taken in either order
	assign awready  = !aw_held && !bvalid;
	assign wready   = !w_held && !bvalid;
	assign do_write = aw_held && w_held;
	assign write_hit = addr_mapped(aw_addr_q);
	assign read_hit  = addr_mapped(araddr);

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_held   <= 1'b0;
			aw_addr_q <= '0;
		end
		else if (awvalid && awready)
		begin
			aw_held   <= 1'b1;
			aw_addr_q <= awaddr;
		end
		else if (do_write)
		begin
			aw_held <= 1'b0;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			w_held   <= 1'b0;
			w_data_q <= 32'h0000_0000;
			w_strb_q <= 4'h0;
		end
		else if (wvalid && wready)
		begin
			w_held   <= 1'b1;
			w_data_q <= wdata;
			w_strb_q <= wstrb;
		end
		else if (do_write)
		begin
			w_held <= 1'b0;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			bvalid <= 1'b0;
			bresp  <= `CTEC_RESP_OKAY;
		end
		else if (do_write)
		begin
			bvalid <= 1'b1;
			bresp  <= write_hit ? `CTEC_RESP_OKAY : `CTEC_RESP_SLVERR;
		end
		else if (bvalid && bready)
		begin
			bvalid <= 1'b0;
		end
	end

	// Read channel: every alias reads back the control register
	assign arready = !rvalid;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rvalid <= 1'b0;
			rdata  <= 32'h0000_0000;
			rresp  <= `CTEC_RESP_OKAY;
		end
		else if (arvalid && arready)
		begin
			rvalid <= 1'b1;
			rdata  <= read_hit ? (ctrl & `CTEC_IMPL_MASK) : 32'h0000_0000;
			rresp  <= read_hit ? `CTEC_RESP_OKAY : `CTEC_RESP_SLVERR;
		end
		else if (rvalid && rready)
		begin
			rvalid <= 1'b0;
		end
	end

	// Three-stage synchronisers; a level counts once stages two and three agree
	genvar g;
	generate
		for (g = 0; g < `CTEC_SRC_W; g++)
		begin : g_sync
			always_ff @(posedge aclk)
			begin
				if (!aresetn)
				begin
					sync1[g]      <= 1'b0;
					sync2[g]      <= 1'b0;
					sync3[g]      <= 1'b0;
					src_stable[g] <= 1'b0;
				end
				else
				begin
					sync1[g] <= sources[g];
					sync2[g] <= sync1[g];
					sync3[g] <= sync2[g];
					if (sync2[g] == sync3[g])
					begin
						src_stable[g] <= sync3[g];
					end
				end
			end
		end
	endgenerate

	assign ss = ctec_src_s'(src_stable);

	// Source tables indexed directly by the select code
	assign first_choices = {ss.comparator_out[2], ss.comparator_out[1], ss.comparator_out[0],
		ss.capture_event[2], ss.capture_event[1], ss.capture_event[0],
		ss.edge_pin[7], ss.edge_pin[6], ss.edge_pin[5], ss.edge_pin[4],
		ss.edge_pin[3], ss.edge_pin[2], ss.edge_pin[0], ss.edge_pin[1],
		ss.compare_unit_one, ss.timer_one_event};
	assign second_choices = {ss.comparator_out[2], ss.comparator_out[1], ss.comparator_out[0],
		ss.peripheral_bus_clock,
		ss.capture_event[2], ss.capture_event[1], ss.capture_event[0],
		ss.edge_pin[12], ss.edge_pin[11], ss.edge_pin[10], ss.edge_pin[9], ss.edge_pin[8],
		ss.edge_pin[0], ss.edge_pin[1],
		ss.compare_unit_one, ss.timer_one_event};

	assign first_in  = first_choices[cf.first_edge_source_sel];
	assign second_in = second_choices[cf.second_edge_source_sel];

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			first_prev  <= 1'b0;
			second_prev <= 1'b0;
		end
		else
		begin
			first_prev  <= first_in;
			second_prev <= second_in;
		end
	end

	// Idle stop halts the unit only while the chip is idle
	assign running = cf.unit_on && !(cf.idle_stop && idle_mode);

	assign first_set = running && cf.edge_gate_enable &&
		edge_event(cf.first_edge_sense_mode, cf.first_edge_polarity, first_in, first_prev);
	assign second_set = running && cf.edge_gate_enable &&
		(!cf.edge_order_enable || cf.first_edge_flag) &&
		edge_event(cf.second_edge_sense_mode, cf.second_edge_polarity, second_in, second_prev);

	// Software write with aliases, then hardware flag sets, which win over a clear
	always_comb
	begin
		logic [31:0] m;
		m = lane_mask(w_strb_q) & w_data_q;
		next_ctrl = ctrl;
		if (do_write && write_hit)
		begin
			case (aw_addr_q)
				`CTEC_ADDR_CTRL: next_ctrl = (ctrl & ~lane_mask(w_strb_q)) | m;
				`CTEC_ADDR_CLR:  next_ctrl = ctrl & ~m;
				`CTEC_ADDR_SET:  next_ctrl = ctrl | m;
				`CTEC_ADDR_INV:  next_ctrl = ctrl ^ m;
				default:         next_ctrl = ctrl;
			endcase
		end
		next_ctrl = next_ctrl & `CTEC_IMPL_MASK;
		// Flags only move by hardware while running; writes land whether running or not
		if (first_set)
		begin
			next_ctrl[`CTEC_BIT_E1_FLAG] = 1'b1;
		end
		if (second_set)
		begin
			next_ctrl[`CTEC_BIT_E2_FLAG] = 1'b1;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			ctrl <= `CTEC_CTRL_RESET;
		end
		else
		begin
			ctrl <= next_ctrl;
		end
	end

	// Flag outputs mirror the register bits so they agree with what the bus reads back; unit_active registers running
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			unit_active      <= 1'b0;
			first_edge_flag  <= 1'b0;
			second_edge_flag <= 1'b0;
		end
		else
		begin
			unit_active      <= running;
			first_edge_flag  <= next_ctrl[`CTEC_BIT_E1_FLAG];
			second_edge_flag <= next_ctrl[`CTEC_BIT_E2_FLAG];
		end
	end

	// Pulse outputs
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			trigger_out <= 1'b0;
			delay_pulse <= 1'b0;
		end
		else
		begin
			// Fires on a hardware set that finds the flag clear; a level-mode second edge keeps the flag but not the trigger
			trigger_out <= cf.trigger_out_enable && second_set && !cf.second_edge_flag;
			// The comparator on the second edge closes the pulse; software must route it there
			delay_pulse <= running && cf.delay_gen_enable &&
				next_ctrl[`CTEC_BIT_E1_FLAG] && !next_ctrl[`CTEC_BIT_E2_FLAG];
		end
	end

	// Current source control
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			analog_ctrl <= '0;
		end
		else
		begin
			// Current flows only between the two edges
			analog_ctrl.source_on     <= running &&
				(next_ctrl[`CTEC_BIT_E1_FLAG] ^ next_ctrl[`CTEC_BIT_E2_FLAG]);
			analog_ctrl.source_ground <= cf.source_ground_enable;
			analog_ctrl.current_trim  <= cf.current_trim;
			analog_ctrl.current_range <= cf.current_range;
		end
	end

endmodule : ctec_top

/* testbench/ctec_chk.sv */
// Port-level assertions for the charge time edge control block
`timescale 1ns/1ns
`include "ctec_map.svh"

module ctec_chk
	import ctec_pkg::*;
(
	input wire logic         aclk,             // Clock
	input wire logic         aresetn,          // Reset, active low
	input wire logic         awvalid,          // Write address valid
	input wire logic         awready,          // Write address ready
	input wire logic         wvalid,           // Write data valid
	input wire logic         wready,           // Write data ready
	input wire logic [1:0]   bresp,            // Write response
	input wire logic         bvalid,           // Write response valid
	input wire logic         bready,           // Write response ready
	input wire logic [7:0]   araddr,           // Read address
	input wire logic         arvalid,          // Read address valid
	input wire logic         arready,          // Read address ready
	input wire logic [31:0]  rdata,            // Read data
	input wire logic [1:0]   rresp,            // Read response
	input wire logic         rvalid,           // Read valid
	input wire logic         rready,           // Read ready
	input wire logic         unit_active,      // Unit running
	input wire logic         first_edge_flag,  // First flag
	input wire logic         second_edge_flag, // Second flag
	input wire logic         trigger_out,      // Trigger pulse
	input wire logic         delay_pulse,      // Delay pulse
	input wire ctec_analog_s analog_ctrl       // Current source control
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence wr_take;
		awvalid && awready && wvalid && wready;
	endsequence
	sequence flag_rise;
		$rose(first_edge_flag) || $rose(second_edge_flag);
	endsequence

	wr_lat_a: assert property (wr_take |-> ##1 !bvalid ##1 bvalid)
		else $error("write answer late or early");
	rd_lat_a: assert property (arvalid && arready |=> rvalid)
		else $error("read answer late");
	b_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
		else $error("write response dropped");
	r_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
		else $error("read response dropped");
	rd_unmap_a: assert property (arvalid && arready && araddr > 8'h0C |=> rresp == 2'h2 && rdata == 32'h0000_0000)
		else $error("unmapped read answered");
	rd_resv_a: assert property (rvalid |-> rdata[17:16] == 2'h0 && !rdata[14])
		else $error("reserved bits read nonzero");
	trig_rise_a: assert property (trigger_out |-> second_edge_flag && !$past(second_edge_flag))
		else $error("trigger without second edge");
	delay_cond_a: assert property (delay_pulse |-> first_edge_flag && !second_edge_flag && unit_active)
		else $error("delay pulse outside edges");
	src_on_a: assert property (analog_ctrl.source_on |-> first_edge_flag ^ second_edge_flag)
		else $error("source on outside edges");
	flag_hold_a: assert property (flag_rise |-> unit_active || bvalid || $past(bvalid) || $past(bvalid, 2))
		else $error("flag set while stopped");
endmodule : ctec_chk

bind ctec_top ctec_chk u_chk (.aclk, .aresetn, .awvalid, .awready, .wvalid, .wready, .bresp, .bvalid,
	.bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .unit_active,
	.first_edge_flag, .second_edge_flag, .trigger_out, .delay_pulse, .analog_ctrl);

/* testbench/ctec_src_model.sv */
// Far-side event sources: timers, captures, comparators and pins
`timescale 1ns/1ns

module ctec_src_model
	import ctec_pkg::*;
(
	input wire logic        aclk,    // Bus clock, echoed as a source
	input wire logic [20:0] want,    // Levels asked for by the bench
	output     ctec_src_s   sources  // Event sources into the block
);
	// Off-grid delay so levels move between clock edges, as real pins do
	assign #37 sources = {aclk, want};
endmodule : ctec_src_model

/* testbench/ctec_tb_top.sv */
// Self-checking bench for the charge time edge control block
`timescale 1ns/1ns
`include "ctec_map.svh"

module ctec_tb_top
	import ctec_pkg::*;
;
	logic         aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic         idle_mode = 0, awready, wready, bvalid, arready, rvalid, unit_active, f1, f2;
	logic         trigger_out, delay_pulse;
	logic [7:0]   awaddr = 8'h00, araddr = 8'h00;
	logic [31:0]  wdata = 32'h0000_0000, rdata, got;
	logic [1:0]   bresp, rresp, resp;
	logic [20:0]  want = 21'h00_0000;
	ctec_analog_s analog_ctrl;
	ctec_src_s    sources;
	int           num_errors = 0, total_checks = 0, trig_cnt = 0, cyc = 0;
	// Bit of the source vector behind each select code; -1 is the bus clock, not driven as a row
	int           src_idx [2][16] = '{'{13, 14, 1, 0, 2, 3, 4, 5, 6, 7, 15, 16, 17, 18, 19, 20},
		'{13, 14, 1, 0, 8, 9, 10, 11, 12, 15, 16, 17, -1, 18, 19, 20}};
	logic [31:0]  blk [3] = '{32'h00CC_8000, 32'h00CC_0800, 32'h00CC_A800};

	ctec_top DUT (.aclk, .aresetn, .awaddr, .awprot(3'h0), .awvalid, .awready, .wdata, .wstrb(4'hF),
		.wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arprot(3'h0), .arvalid, .arready, .rdata,
		.rresp, .rvalid, .rready, .sources, .idle_mode, .unit_active, .first_edge_flag(f1),
		.second_edge_flag(f2), .trigger_out, .delay_pulse, .analog_ctrl);
	ctec_src_model u_src (.aclk, .want, .sources);

	initial forever #50 aclk = ~aclk;

	always @(posedge aclk)
	begin
		cyc++;
		if (trigger_out === 1'b1)
			trig_cnt++;
		if (cyc == 20000)
		begin
			num_errors++;
			tally_and_finish();
		end
	end

	task automatic tally_and_finish;
		if (num_errors == 0 && total_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : tally_and_finish

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	task automatic tick(input int n);
		repeat (n) @(posedge aclk);
	endtask : tick

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (awready === 1'b1)
				awvalid <= 1'b0;
			if (wready === 1'b1)
				wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		resp = bresp;
		bready <= 1'b0;
		// One edge passes so a following request never reuses this time step
		@(posedge aclk);
	endtask : wr

	task automatic rd(input logic [7:0] a);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (arready === 1'b1)
				arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		got = rdata;
		resp = rresp;
		rready <= 1'b0;
		@(posedge aclk);
	endtask : rd

	initial
	begin
		tick(6);
		aresetn <= 1'b1;
		tick(1);
		// Other edge watches for a falling edge so a shared source bit cannot set it
		for (int e = 0; e < 2; e++)
			for (int c = 0; c < 16; c++)
				if (src_idx[e][c] >= 0)
				begin
					wr(8'h00, 32'h8080_8800 | (e ? 32'h0040_0000 | (32'(c) << 18) : 32'h4000_0000 | (32'(c) << 26)));
					want[src_idx[e][c]] <= 1'b1;
					tick(8);
					chk("first flag", f1, e == 0);
					chk("second flag", f2, e == 1);
					want <= 21'h00_0000;
					tick(6);
				end
		chk("trigger off", trig_cnt, 0);
		wr(8'h04, 32'hFFFF_FFFF);
		rd(8'h00);
		chk("cleared", got, 32'h0000_0000);
		wr(8'h00, 32'hFFFF_FFFF);
		rd(8'h00);
		chk("reserved", got, 32'hFFFC_BFFF);
		chk("ground", analog_ctrl.source_ground, 1'b1);
		chk("range", analog_ctrl.current_range, 2'h3);
		wr(8'h04, 32'hFFFF_FFFF);
		chk("ground off", analog_ctrl.source_ground, 1'b0);
		wr(8'h08, 32'h0000_007D);
		chk("trim max", analog_ctrl.current_trim, 6'h1F);
		wr(8'h0C, 32'h0000_00F8);
		wr(8'h10, 32'hFFFF_FFFF);
		chk("unmapped write", resp, 2'h2);
		rd(8'h00);
		chk("alias", got, 32'h0000_0085);
		chk("trim min", analog_ctrl.current_trim, 6'h21);
		chk("range base", analog_ctrl.current_range, 2'h1);
		rd(8'h10);
		chk("unmapped read", {resp, got[29:0]}, 32'h8000_0000);
		wr(8'h00, 32'h40CC_8800);
		want <= 21'h00_2000;
		tick(8);
		wr(8'h04, 32'h0100_0000);
		tick(4);
		chk("level holds", f1, 1'b1);
		wr(8'h00, 32'hC0CC_8800);
		// The level set in the switching cycle beats the written zero
		chk("set wins", f1, 1'b1);
		wr(8'h04, 32'h0100_0000);
		tick(8);
		chk("edge once", f1, 1'b0);
		wr(8'h00, 32'h80CC_8800);
		tick(8);
		chk("no fall yet", f1, 1'b0);
		want <= 21'h00_0000;
		tick(8);
		chk("falling", f1, 1'b1);
		idle_mode <= 1'b1;
		foreach (blk[i])
		begin
			wr(8'h00, blk[i] | 32'hC000_0000);
			want <= 21'h00_2000;
			tick(8);
			chk("blocked", f1, 1'b0);
			chk("active", unit_active, i == 0);
			want <= 21'h00_0000;
			tick(6);
		end
		wr(8'h08, 32'h0100_0000);
		tick(2);
		chk("soft set", f1, 1'b1);
		wr(8'h00, 32'hC0CC_8800);
		want <= 21'h00_2000;
		tick(8);
		chk("idle run", f1, 1'b1);
		idle_mode <= 1'b0;
		want <= 21'h00_0000;
		tick(6);
		trig_cnt = 0;
		// Delay generation needs the second comparator as second source
		wr(8'h00, 32'hC0F8_9D00);
		want <= 21'h08_0000;
		tick(8);
		chk("order", f2, 1'b0);
		want <= 21'h00_2000;
		tick(8);
		chk("delay", delay_pulse, 1'b1);
		chk("source on", analog_ctrl.source_on, 1'b1);
		want <= 21'h08_2000;
		tick(8);
		chk("second", f2, 1'b1);
		chk("trigger", trig_cnt, 1);
		chk("delay end", delay_pulse, 1'b0);
		aresetn <= 1'b0;
		tick(6);
		aresetn <= 1'b1;
		tick(1);
		rd(8'h00);
		chk("second reset", {got[31:1], f1}, 32'h0000_0000);
		tally_and_finish();
	end
endmodule : ctec_tb_top
